// *** common/scr_pkg.sv ***
package scr_pkg;

  // ==========================================================================
  // register offsets (plain port address)
  localparam logic [1:0] SCR_OFS_CTRL   = 2'h0;
  localparam logic [1:0] SCR_OFS_STAT   = 2'h1;
  localparam logic [1:0] SCR_OFS_DATA   = 2'h2;

  // ==========================================================================
  // serial_control bit positions
  localparam int SCR_CTL_RXIE   = 7;
  localparam int SCR_CTL_MSTR   = 5;
  localparam int SCR_CTL_CLOCK_IDLE_LEVEL   = 4;
  localparam int SCR_CTL_CLOCK_PHASE_SELECT   = 3;
  localparam int SCR_CTL_ODRN   = 2;
  localparam int SCR_CTL_EN     = 1;
  localparam int SCR_CTL_TXIE   = 0;

  // serial_status_control bit positions
  localparam int SCR_ST_RXF     = 7;
  localparam int SCR_ST_ERROR_IRQ_ENABLE   = 6;
  localparam int SCR_ST_OVR     = 5;
  localparam int SCR_ST_MODE_FAULT_FLAG    = 4;
  localparam int SCR_ST_TXE     = 3;
  localparam int SCR_ST_MFEN    = 2;
  localparam int SCR_ST_RATE    = 0;

  // ==========================================================================
  // reset values
  localparam logic [7:0] SCR_CTRL_RST = 8'h28;
  localparam logic [7:0] SCR_STAT_RST = 8'h08;

  // ==========================================================================
  // rate divisor half periods in bus clocks (divisors 2, 8, 32, 128)
  localparam logic [6:0] SCR_HALF_DIV2   = 7'h01;
  localparam logic [6:0] SCR_HALF_DIV8   = 7'h04;
  localparam logic [6:0] SCR_HALF_DIV32  = 7'h10;
  localparam logic [6:0] SCR_HALF_DIV128 = 7'h40;
  localparam logic [3:0] SCR_BITS        = 4'h8;

endpackage : scr_pkg

// *** rtl/scr_shifter.sv ***
`timescale 1ns/1ps
// byte shift engine: master clock generation or slave sampling
module scr_shifter
  import scr_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // configuration
  input  wire logic       enable_in,
  input  wire logic       master_in,
  input  wire logic       clock_idle_level_in,
  input  wire logic       clock_phase_select_in,
  input  wire logic [6:0] half_in,
  // byte exchange
  input  wire logic       load_in,
  input  wire logic [7:0] tx_byte_in,
  output logic            busy_out,
  output logic            done_out,
  output logic [7:0]      rx_byte_out,
  // synchronised pins
  input  wire logic       sclk_in,
  input  wire logic       sel_n_in,
  input  wire logic       sdi_in,
  output logic            sclk_out,
  output logic            sdo_out
);

  typedef struct packed {
    logic       busy;
    logic       done;
    logic [6:0] cnt;
    logic [3:0] edges;
    logic [3:0] nsmp;
    logic [1:0] pipe;
    logic       sck;
    logic       sck_d;
    logic [7:0] sh;
    logic [7:0] rsh;
    logic [7:0] rx;
  } scr_sh_t;

  scr_sh_t st_r;
  scr_sh_t st_nxt;
  logic    lead;
  logic    trail;
  logic    samp;
  logic    drive;
  logic    take;

  // ==========================================================================
  // next state: master counts half periods, slave follows pin edges
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.done  = 1'b0;
    st_nxt.sck_d = sclk_in;
    lead         = 1'b0;
    trail        = 1'b0;
    if (!enable_in)
    begin
      st_nxt.busy  = 1'b0;
      st_nxt.edges = 4'h0;
      st_nxt.nsmp  = 4'h0;
      st_nxt.sck   = clock_idle_level_in;
    end
    else if (master_in)
    begin
      if (!st_r.busy)
      begin
        st_nxt.sck = clock_idle_level_in;
        if (load_in)
        begin
          st_nxt.busy  = 1'b1;
          st_nxt.sh    = tx_byte_in;
          st_nxt.cnt   = half_in;
          st_nxt.edges = 4'h0;
          st_nxt.nsmp  = 4'h0;
        end
      end
      // clock parked at idle until the last delayed sample lands
      else if (st_r.edges == SCR_BITS)
      begin
        if (st_r.pipe == 2'b00)
        begin
          st_nxt.busy  = 1'b0;
          st_nxt.edges = 4'h0;
        end
      end
      else if (st_r.cnt == 7'h01)
      begin
        st_nxt.cnt = half_in;
        st_nxt.sck = ~st_r.sck;
        // leading edge leaves idle level, trailing edge returns to it
        if (st_r.sck == clock_idle_level_in)
          lead = 1'b1;
        else
          trail = 1'b1;
      end
      else
        st_nxt.cnt = st_r.cnt - 7'h01;
    end
    else
    begin
      // deselected slave ignores clocks, even mid-byte
      if (sel_n_in)
      begin
        st_nxt.busy  = 1'b0;
        st_nxt.edges = 4'h0;
        st_nxt.nsmp  = 4'h0;
      end
      else
      begin
        if (!st_r.busy && load_in)
          st_nxt.sh = tx_byte_in;
        if (sclk_in != st_r.sck_d)
        begin
          st_nxt.busy = 1'b1;
          if (sclk_in != clock_idle_level_in)
            lead = 1'b1;
          else
            trail = 1'b1;
        end
      end
    end
    // output moves only on drive edges so the far side never races it
    samp  = clock_phase_select_in ? trail : lead;
    drive = clock_phase_select_in ? (lead && (st_r.edges != 4'h0)) : trail;
    // master sample waits out the two pin flops before taking the bit
    if (enable_in && master_in)
      st_nxt.pipe = {st_r.pipe[0], samp};
    else
      st_nxt.pipe = 2'b00;
    take = enable_in && (master_in ? st_r.pipe[1] : samp);
    if (drive)
      st_nxt.sh = {st_nxt.sh[6:0], 1'b0};
    if (trail)
    begin
      st_nxt.edges = st_r.edges + 4'h1;
      if (!master_in && (st_r.edges == SCR_BITS - 4'h1))
      begin
        st_nxt.busy  = 1'b0;
        st_nxt.edges = 4'h0;
      end
    end
    if (take)
    begin
      st_nxt.rsh  = {st_r.rsh[6:0], sdi_in};
      st_nxt.nsmp = st_r.nsmp + 4'h1;
      if (st_r.nsmp == SCR_BITS - 4'h1)
      begin
        st_nxt.done = 1'b1;
        st_nxt.nsmp = 4'h0;
        st_nxt.rx   = {st_r.rsh[6:0], sdi_in};
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign busy_out    = st_r.busy;
  assign done_out    = st_r.done;
  assign rx_byte_out = st_r.rx;
  assign sclk_out    = st_r.sck;
  assign sdo_out     = st_r.sh[7];

endmodule : scr_shifter

// *** rtl/scr_regs.sv ***
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
// Summary of operation
// (RULE1) receive-full requests interrupt only while rx enable is set
// (RULE2) master select one gives master, zero gives slave
// (RULE3) polarity sets idle clock level; both ends must match
// (RULE4) both ends share phase; phase zero needs select high between bytes
// (RULE5) open-drain select makes clock and data pins open-drain
// (RULE6) enable turns module on; clearing it partially resets logic
// (RULE7) rx full set on byte arrival; cleared by status then data read
// (RULE8) error enable gates mode-fault and overrun requests
// (RULE9) overrun set on byte before read; older byte kept
// (RULE10) overrun cleared by status read with flag then data read
// (RULE11) slave with fault enable flags select high mid-transfer
// (RULE12) master with fault enable flags select low anytime
// (RULE13) mode fault cleared by status read then control write
// (RULE14) tx empty set when transmit byte moves to shifter
// (RULE15) tx enable gates tx empty request
// (RULE16) tx empty cleared by data register write
// (RULE17) software writes data only while tx empty is set
// (RULE18) fault enable gates setting; clearing it keeps flag
// (RULE19) master without fault enable ignores select pin, freed as gpio
// (RULE20) slave always uses select pin; fault enable only gates flag
// (RULE21) master rate code divides bus clock by 2, 8, 32, 128
// (RULE22) data write loads tx buffer, read returns rx; both survive reset
// (RULE23) no read-modify-write on data register
// (RULE24) rx full and error flags merge into one request
// (RULE25) tx empty request needs module enable
// (RULE26) flags read-only; set wins over clearing step
module scr_regs
  import scr_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // register port
  input  wire logic [1:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic [7:0]      rdata_out,
  // interrupt requests
  output logic            rx_err_irq_out,
  output logic            tx_irq_out,
  // serial clock pin
  input  wire logic       sclk_pin_in,
  output logic            sclk_pin_out,
  output logic            sclk_pin_oe_out,
  // master out pin
  input  wire logic       mosi_pin_in,
  output logic            mosi_pin_out,
  output logic            mosi_pin_oe_out,
  // master in pin
  input  wire logic       miso_pin_in,
  output logic            miso_pin_out,
  output logic            miso_pin_oe_out,
  // slave select pin, active low
  input  wire logic       sel_n_pin_in,
  output logic            sel_gpio_out
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic       error_irq_enable;
    logic       mfen;
    logic [1:0] rate;
    logic       rxf;
    logic       ovr;
    logic       mode_fault_flag;
    logic       txe;
    logic       arm_rx;
    logic       arm_mf;
    logic       pend;
    logic [7:0] rdata;
    logic [2:0] s1;
    logic [2:0] s2;
    logic       sel_prev;
  } scr_st_t;

  scr_st_t    st_r;
  scr_st_t    st_nxt;
  logic [7:0] tx_buf_r;
  logic [7:0] rx_buf_r;
  logic       en;
  logic       mstr;
  logic       busy;
  logic       done;
  logic [7:0] rx_byte;
  logic [6:0] half;
  logic       sclk_s;
  logic       sel_n_s;
  logic       sdi;
  logic       sck_o;
  logic       sdo_o;
  logic       load;

  // decode of a register access at one offset
  function automatic logic hit(input logic [1:0] a, input logic [1:0] o);
    hit = (a == o);
  endfunction : hit

  assign en      = st_r.ctrl[SCR_CTL_EN];                  // RULE6
  assign mstr    = st_r.ctrl[SCR_CTL_MSTR];                // RULE2
  assign sclk_s  = st_r.s2[0];
  assign sel_n_s = st_r.s2[1];
  assign sdi     = st_r.s2[2];

  // ==========================================================================
  // rate divisor select, only the master uses it
  always_comb
  begin
    case (st_r.rate)                                       // RULE21
      2'h0:    half = SCR_HALF_DIV2;
      2'h1:    half = SCR_HALF_DIV8;
      2'h2:    half = SCR_HALF_DIV32;
      2'h3:    half = SCR_HALF_DIV128;
      default: half = SCR_HALF_DIV2;
    endcase
  end

  // pending byte hands over when shifter idle
  assign load = st_r.pend && !busy && en;                  // RULE14

  scr_shifter u_shift (
    .sys_clk_in  (sys_clk_in),
    .sys_rst_in  (sys_rst_in),
    .enable_in   (en),
    .master_in   (mstr),
    .clock_idle_level_in     (st_r.ctrl[SCR_CTL_CLOCK_IDLE_LEVEL]),
    .clock_phase_select_in     (st_r.ctrl[SCR_CTL_CLOCK_PHASE_SELECT]),
    .half_in     (half),
    .load_in     (load),
    .tx_byte_in  (tx_buf_r),
    .busy_out    (busy),
    .done_out    (done),
    .rx_byte_out (rx_byte),
    .sclk_in     (sclk_s),
    .sel_n_in    (sel_n_s),
    .sdi_in      (sdi),
    .sclk_out    (sck_o),
    .sdo_out     (sdo_o)
  );

  // ==========================================================================
  // register and flag next state
  always_comb
  begin
    st_nxt = st_r;
    // pins pass two flops before use
    st_nxt.s1 = {mstr ? miso_pin_in : mosi_pin_in, sel_n_pin_in,
                 sclk_pin_in};
    st_nxt.s2 = st_r.s1;
    st_nxt.sel_prev = sel_n_s;
    // read data stands one cycle
    st_nxt.rdata = 8'h00;
    if (rd_in)
    begin
      if (hit(addr_in, SCR_OFS_CTRL))
        st_nxt.rdata = st_r.ctrl;
      else if (hit(addr_in, SCR_OFS_STAT))
        st_nxt.rdata = {st_r.rxf, st_r.error_irq_enable, st_r.ovr, st_r.mode_fault_flag,
                        st_r.txe, st_r.mfen, st_r.rate};
      else if (hit(addr_in, SCR_OFS_DATA))
        st_nxt.rdata = rx_buf_r;                           // RULE22
    end
    // first step of two-step clears: status read with flag set
    if (rd_in && hit(addr_in, SCR_OFS_STAT))
    begin
      st_nxt.arm_rx = st_r.rxf || st_r.ovr;
      st_nxt.arm_mf = st_r.mode_fault_flag;
    end
    // second steps
    if (rd_in && hit(addr_in, SCR_OFS_DATA) && st_r.arm_rx)
    begin
      st_nxt.rxf    = 1'b0;                                // RULE7
      st_nxt.ovr    = 1'b0;                                // RULE10
      st_nxt.arm_rx = 1'b0;
    end
    if (wr_in && hit(addr_in, SCR_OFS_CTRL))
    begin
      st_nxt.ctrl = wdata_in & 8'hbf;
      if (st_r.arm_mf)
      begin
        st_nxt.mode_fault_flag   = 1'b0;                              // RULE13
        st_nxt.arm_mf = 1'b0;
      end
    end
    // flag bits ignore writes; only control fields stored
    if (wr_in && hit(addr_in, SCR_OFS_STAT))
    begin
      st_nxt.error_irq_enable = wdata_in[SCR_ST_ERROR_IRQ_ENABLE];
      st_nxt.mfen  = wdata_in[SCR_ST_MFEN];                // RULE18
      st_nxt.rate  = wdata_in[SCR_ST_RATE +: 2];           // RULE26
    end
    if (wr_in && hit(addr_in, SCR_OFS_DATA))
    begin
      st_nxt.txe  = 1'b0;                                  // RULE16
      st_nxt.pend = 1'b1;
    end
    // hardware sets follow the register-access clears so they beat them; the disable clears below still win
    if (load)
    begin
      st_nxt.txe  = 1'b1;                                  // RULE14
      st_nxt.pend = 1'b0;
    end
    if (done)
    begin
      if (st_r.rxf)
        st_nxt.ovr = 1'b1;                                 // RULE9
      else
        st_nxt.rxf = 1'b1;                                 // RULE7
    end
    if (en && st_r.mfen)                                   // RULE18
    begin
      if (mstr && !sel_n_s)
        st_nxt.mode_fault_flag = 1'b1;                                // RULE12
      if (!mstr && busy && sel_n_s && !st_r.sel_prev)
        st_nxt.mode_fault_flag = 1'b1;                                // RULE11
    end
    // disable: partial reset of transfer state and flags
    if (!en)
    begin
      st_nxt.pend   = 1'b0;                                // RULE6
      st_nxt.txe    = 1'b1;
      st_nxt.rxf    = 1'b0;
      st_nxt.ovr    = 1'b0;
      st_nxt.arm_rx = 1'b0;
    end
  end

  // state register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_r       <= '0;
      st_r.ctrl  <= SCR_CTRL_RST;
      st_r.txe   <= SCR_STAT_RST[SCR_ST_TXE];
      st_r.sel_prev <= 1'b1;
    end
    else
    begin
      st_r       <= st_nxt;
    end
  end

  // data buffers have no reset so contents survive it
  always_ff @(posedge sys_clk_in)
  begin
    if (wr_in && hit(addr_in, SCR_OFS_DATA))
      tx_buf_r <= wdata_in;                                // RULE22
    if (done && !st_r.rxf)
      rx_buf_r <= rx_byte;                                 // RULE9
  end

  // ==========================================================================
  // interrupt requests
  assign rx_err_irq_out = (st_r.rxf && st_r.ctrl[SCR_CTL_RXIE])   // RULE1
                        || (st_r.error_irq_enable                            // RULE8
                            && (st_r.mode_fault_flag || st_r.ovr));          // RULE24
  assign tx_irq_out     = st_r.txe && st_r.ctrl[SCR_CTL_TXIE]     // RULE15
                        && en;                                    // RULE25

  assign rdata_out = st_r.rdata;

  // ==========================================================================
  // pins: open-drain drives only lows
  always_comb
  begin
    sclk_pin_out    = mstr ? sck_o : 1'b0;                 // RULE3
    mosi_pin_out    = sdo_o;
    miso_pin_out    = sdo_o;
    sclk_pin_oe_out = en && mstr;
    mosi_pin_oe_out = en && mstr;
    miso_pin_oe_out = en && !mstr && !sel_n_s;
    if (st_r.ctrl[SCR_CTL_ODRN])                           // RULE5
    begin
      sclk_pin_oe_out = sclk_pin_oe_out && !sclk_pin_out;
      mosi_pin_oe_out = mosi_pin_oe_out && !mosi_pin_out;
      miso_pin_oe_out = miso_pin_oe_out && !miso_pin_out;
    end
  end

  // select pin free for gpio unless enabled as slave or as faulting master
  assign sel_gpio_out = !en || (mstr && !st_r.mfen);       // RULE19 RULE20

  // ==========================================================================
  // checks
  a_rx_irq_gate: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) (st_r.rxf && !st_r.ctrl[SCR_CTL_RXIE] && !st_r.error_irq_enable)
    |-> !rx_err_irq_out) else $error("rx irq not gated"); // RULE1
  a_tx_irq_gate: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) tx_irq_out |-> (en && st_r.txe))
    else $error("tx irq without enable"); // RULE25
  a_data_wr_clr: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) (wr_in && hit(addr_in, SCR_OFS_DATA) && !load && en)
    |=> !st_r.txe) else $error("tx empty not cleared"); // RULE16
  a_done_sets_rx: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) (done && en) |=> (st_r.rxf || st_r.ovr))
    else $error("byte arrival lost"); // RULE7
  a_ovr_keeps: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) (done && st_r.rxf && en) |=> (st_r.ovr &&
    $stable(rx_buf_r))) else $error("overrun handling wrong"); // RULE9
  a_mode_fault_flag_master: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) (en && mstr && st_r.mfen && !sel_n_s) |=> st_r.mode_fault_flag)
    else $error("master fault missed"); // RULE12
  a_mode_fault_flag_hold: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) (st_r.mode_fault_flag && !(wr_in && hit(addr_in, SCR_OFS_CTRL)))
    |=> st_r.mode_fault_flag) else $error("mode fault lost"); // RULE18
  a_rdata_zero: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) !rd_in |=> (rdata_out == 8'h00))
    else $error("read data stands too long"); // RULE26

  // two-step clears, built from their second steps
  sequence s_rx_armed;
    st_r.arm_rx && rd_in && hit(addr_in, SCR_OFS_DATA);
  endsequence

  sequence s_mf_armed;
    st_r.arm_mf && wr_in && hit(addr_in, SCR_OFS_CTRL);
  endsequence

  a_rx_two_step: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) s_rx_armed ##0 !done |=> !st_r.rxf)
    else $error("rx full not cleared"); // RULE7
  a_ovr_two_step: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) s_rx_armed ##0 !done |=> !st_r.ovr)
    else $error("overrun not cleared"); // RULE10
  a_mf_two_step: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) s_mf_armed ##0 !(en && st_r.mfen) |=> !st_r.mode_fault_flag)
    else $error("mode fault not cleared"); // RULE13
  a_txe_on_load: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) load |=> st_r.txe)
    else $error("tx empty not set on load"); // RULE14
  a_odrn_sclk: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) (st_r.ctrl[SCR_CTL_ODRN] && sclk_pin_oe_out)
    |-> !sclk_pin_out) else $error("open-drain drove high"); // RULE5
  a_mode_fault_flag_slave: assert property (@(posedge sys_clk_in) disable iff
    (sys_rst_in) (en && !mstr && st_r.mfen && busy && sel_n_s &&
    !st_r.sel_prev) |=> st_r.mode_fault_flag)
    else $error("slave fault missed"); // RULE11

endmodule : scr_regs

// *** verif/scr_peer.sv ***
`timescale 1ns/1ps
// ==========================================================================
// far-side serial slave, behavioural, driven by pin edges only
module scr_peer
(
  // link pins
  input  wire logic       sclk_in,
  input  wire logic       mosi_in,
  input  wire logic       sel_n_in,
  output logic            miso_out,
  output logic            miso_oe_out,
  // setup, must match the block
  input  wire logic       clock_idle_level_in,
  input  wire logic       clock_phase_select_in,
  input  wire logic [7:0] tx_base_in,
  // received bytes
  output logic [7:0]      rx_byte_out,
  output logic [7:0]      rx_count_out
);
  logic [7:0] sh;
  logic [2:0] nbit;
  logic       lead;

  // polarity only moves the idle level, edges are counted from it
  assign lead        = sclk_in ^ clock_idle_level_in;
  // released when not selected, the pull-up takes over
  assign miso_oe_out = ~sel_n_in;

  initial
  begin
    sh           = 8'h00;
    nbit         = 3'h0;
    miso_out     = 1'b0;
    rx_byte_out  = 8'h00;
    rx_count_out = 8'h00;
  end

  // new frame: each byte sent is the base plus the bytes seen so far
  always @(negedge sel_n_in)
  begin
    nbit = 3'h0;
    sh   = tx_base_in + rx_count_out;
    if (!clock_phase_select_in)
      miso_out = sh[7];
  end

  // phase picks which edge samples and which edge drives
  always @(lead)
  begin
    if (!sel_n_in)
    begin
      if (lead ^ clock_phase_select_in)
      begin
        sh   = {sh[6:0], mosi_in};
        nbit = nbit + 3'h1;
        if (nbit == 3'h0)
        begin
          rx_byte_out  = sh;
          rx_count_out = rx_count_out + 8'h01;
          sh           = tx_base_in + rx_count_out;
        end
      end
      else
        miso_out = sh[7];
    end
  end
endmodule : scr_peer

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import scr_pkg::*;
;
  typedef struct packed {logic [1:0] a; logic [7:0] d; logic [7:0] e;} scr_row_t;
  logic       clk, rst, wr, rd, sel_n, peer_sel_n, peer_clock_idle_level, peer_clock_phase_select;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, peer_base, peer_rx, peer_cnt, nb, cc, ctl, last;
  logic       rx_irq, tx_irq, sel_gpio, peer_miso, peer_oe;
  logic       sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  wire        sclk_w, mosi_w, miso_w;
  int         num_errors, num_checks;
  time        t0, t1;
  logic [7:0] div_tab [4] = '{8'h02, 8'h08, 8'h20, 8'h80};
  // writable bits read back, flag bits and bit 6 ignore writes
  scr_row_t   rows [6] = '{'{2'h0, 8'hff, 8'hbf}, '{2'h1, 8'hff, 8'h4f},
                           '{2'h1, 8'h00, 8'h08}, '{2'h0, 8'h00, 8'h00},
                           '{2'h3, 8'hff, 8'h00}, '{2'h0, 8'h28, 8'h28}};

  // ========================================================================
  // pins: released lines float high through the port pull-ups
  assign sclk_w = sclk_oe ? sclk_o : 1'b1;
  assign mosi_w = mosi_oe ? mosi_o : 1'b1;
  assign miso_w = miso_oe ? miso_o : (peer_oe ? peer_miso : 1'b1);

  scr_regs i_scr_regs (.sys_clk_in(clk), .sys_rst_in(rst), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .rx_err_irq_out(rx_irq), .tx_irq_out(tx_irq), .sclk_pin_in(sclk_w),
    .sclk_pin_out(sclk_o), .sclk_pin_oe_out(sclk_oe), .mosi_pin_in(mosi_w),
    .mosi_pin_out(mosi_o), .mosi_pin_oe_out(mosi_oe), .miso_pin_in(miso_w),
    .miso_pin_out(miso_o), .miso_pin_oe_out(miso_oe),
    .sel_n_pin_in(sel_n), .sel_gpio_out(sel_gpio));

  scr_peer i_scr_peer (.sclk_in(sclk_w), .mosi_in(mosi_w),
    .sel_n_in(peer_sel_n), .miso_out(peer_miso), .miso_oe_out(peer_oe),
    .clock_idle_level_in(peer_clock_idle_level), .clock_phase_select_in(peer_clock_phase_select), .tx_base_in(peer_base),
    .rx_byte_out(peer_rx), .rx_count_out(peer_cnt));

  // ========================================================================
  // checks and bus cycles
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t bit got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    // let the written fields settle before anything looks at outputs
    @(posedge clk);
    #1;
  endtask : bus_wr

  // read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk_byte(rdata, exp);
  endtask : chk_rd

  // bounded wait for the far side to count n bytes, then let flags settle
  task automatic wait_rx(input logic [7:0] n);
    int k;
    k = 0;
    while (peer_cnt !== n && k < 4000)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 4000)
      num_errors++;
    repeat (6) @(posedge clk);
  endtask : wait_rx

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // ========================================================================
  // clock and watchdog (longest transfer is about a thousand cycles)
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #200us;
    num_errors++;
    close_out();
  end

  // ========================================================================
  // main sequence
  initial
  begin
    {rst, sel_n, peer_sel_n, peer_clock_phase_select} = 4'hf;
    {wr, rd, peer_clock_idle_level, addr, wdata, nb} = '0;
    peer_base = 8'h3c;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_rd(SCR_OFS_CTRL, 8'h28);
    chk_rd(SCR_OFS_STAT, 8'h08);
    chk_bit(sclk_oe | mosi_oe | miso_oe, 1'b0);
    foreach (rows[i])
    begin
      bus_wr(rows[i].a, rows[i].d);
      chk_rd(rows[i].a, rows[i].e);
    end
    // one byte per rate code, polarity, phase and enables varied
    for (int c = 0; c < 4; c++)
    begin
      cc  = {6'h00, c[1:0]};
      ctl = {c[0], 2'b01, c[1], (c != 2), 2'b01, c[0]};
      peer_clock_idle_level <= c[1];
      peer_clock_phase_select <= (c != 2);
      bus_wr(SCR_OFS_CTRL, ctl);
      bus_wr(SCR_OFS_STAT, cc);
      peer_sel_n <= 1'b0;
      chk_bit(sclk_w, c[1]);
      bus_wr(SCR_OFS_DATA, 8'ha5 ^ cc);
      @(posedge sclk_w);
      t0 = $time;
      @(posedge sclk_w);
      t1 = $time;
      chk_byte(8'((t1 - t0) / 10), div_tab[c]);
      wait_rx(nb + 8'h01);
      chk_byte(peer_rx, 8'ha5 ^ cc);
      chk_rd(SCR_OFS_STAT, 8'h88 | cc);
      chk_bit(rx_irq, c[0]);
      chk_bit(tx_irq, c[0]);
      chk_rd(SCR_OFS_DATA, peer_base + nb);
      chk_rd(SCR_OFS_STAT, 8'h08 | cc);
      nb = nb + 8'h01;
      peer_sel_n <= 1'b1;
    end
    // two bytes back to back, first one left unread
    peer_clock_idle_level <= 1'b0;
    peer_clock_phase_select <= 1'b1;
    bus_wr(SCR_OFS_CTRL, 8'h2b);
    bus_wr(SCR_OFS_STAT, 8'h40);
    peer_sel_n <= 1'b0;
    bus_wr(SCR_OFS_DATA, 8'h11);
    bus_wr(SCR_OFS_DATA, 8'h22);
    chk_rd(SCR_OFS_STAT, 8'h40);
    chk_bit(tx_irq, 1'b0);
    wait_rx(nb + 8'h02);
    chk_rd(SCR_OFS_STAT, 8'he8);
    chk_bit(rx_irq, 1'b1);
    last = peer_base + nb;
    chk_rd(SCR_OFS_DATA, last);
    chk_rd(SCR_OFS_STAT, 8'h48);
    chk_bit(rx_irq, 1'b0);
    peer_sel_n <= 1'b1;
    // select driven low under a master with fault detection
    bus_wr(SCR_OFS_STAT, 8'h44);
    chk_bit(sel_gpio, 1'b0);
    sel_n <= 1'b0;
    repeat (6) @(posedge clk);
    sel_n <= 1'b1;
    chk_rd(SCR_OFS_STAT, 8'h5c);
    chk_bit(rx_irq, 1'b1);
    bus_wr(SCR_OFS_STAT, 8'h40);
    chk_rd(SCR_OFS_STAT, 8'h58);
    bus_wr(SCR_OFS_CTRL, 8'h2a);
    chk_rd(SCR_OFS_STAT, 8'h48);
    chk_bit(sel_gpio, 1'b1);
    bus_wr(SCR_OFS_CTRL, 8'h0a);
    chk_bit(sel_gpio, 1'b0);
    chk_bit(sclk_oe, 1'b0);
    // idle clock: open-drain releases a high level, push-pull drives it
    bus_wr(SCR_OFS_CTRL, 8'h3e);
    chk_bit(sclk_oe, 1'b0);
    bus_wr(SCR_OFS_CTRL, 8'h2e);
    chk_bit(sclk_oe & ~sclk_w, 1'b1);
    bus_wr(SCR_OFS_CTRL, 8'h3a);
    chk_bit(sclk_oe & sclk_w, 1'b1);
    // disable with tx interrupt enabled
    bus_wr(SCR_OFS_CTRL, 8'h39);
    chk_bit(tx_irq, 1'b0);
    chk_bit(sclk_oe | mosi_oe | miso_oe, 1'b0);
    // second reset keeps the receive buffer
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_rd(SCR_OFS_DATA, last);
    close_out();
  end
endmodule : testbench
